//--- design/bfw_regs.sv
// forwarding window register bank with axi4-lite slave and window hit decode
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
module bfw_regs (
  input wire logic mclk_in, // 10 mhz clock
  input wire logic reset_in, // synchronous active high reset
  input wire logic [7:0] awaddr_in, // write address
  input wire logic awvalid_in, // write address valid
  output logic awready_out, // write address ready
  input wire logic [31:0] wdata_in, // write data
  input wire logic [3:0] wstrb_in, // write byte strobes
  input wire logic wvalid_in, // write data valid
  output logic wready_out, // write data ready
  output logic [1:0] bresp_out, // write response
  output logic bvalid_out, // write response valid
  input wire logic bready_in, // write response ready
  input wire logic [7:0] araddr_in, // read address
  input wire logic arvalid_in, // read address valid
  output logic arready_out, // read address ready
  output logic [31:0] rdata_out, // read data
  output logic [1:0] rresp_out, // read response
  output logic rvalid_out, // read data valid
  input wire logic rready_in, // read data ready
  input wire logic [11:0] mem_bottom_in, // memory window bottom, address bits 31:20
  input wire logic [3:0] io_bottom_low_in, // io window bottom, address bits 15:12
  input wire logic [3:0] io_top_low_in, // io window top, address bits 15:12
  input wire logic [63:0] mem_addr_in, // memory address under decode
  input wire logic [31:0] io_addr_in, // io address under decode
  output logic mem_hit_out, // address in non-prefetchable window
  output logic pref_hit_out, // address in prefetchable window
  output logic io_hit_out // address in io window
);
  import bfw_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic awready_q;
  logic wready_q;
  logic arready_q;
  logic [11:0] mem_top_q;
  logic [11:0] pref_bot_q;
  logic [11:0] pref_top_q;
  logic [31:0] pbot_hi_q;
  logic [31:0] ptop_hi_q;
  logic [15:0] io_bot_hi_q;
  logic [15:0] io_top_hi_q;

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // each of address and data is taken once, in either order; bvalid blocks new ones
  // a channel is taken only at an edge where its registered ready is high, so both sides agree on the handshake
  wire aw_take = awvalid_in && awready_q && !aw_held_q && !bvalid_q;
  wire w_take = wvalid_in && wready_q && !w_held_q && !bvalid_q;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire [7:0] wr_word = {aw_addr_q[7:2], 2'b00};
  wire wr_mapped = (wr_word == BFW_OFF_MEM) || (wr_word == BFW_OFF_PREF) || (wr_word == BFW_OFF_PBOT_HI) ||
    (wr_word == BFW_OFF_PTOP_HI) || (wr_word == BFW_OFF_IO_HI) || (wr_word == BFW_OFF_CAP);

  // byte-lane merge of a 32-bit old word with the held write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] stb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  wire [31:0] mem_word = {mem_top_q, 4'h0, 16'h0000};
  wire [31:0] pref_word = {pref_top_q, BFW_ADDR_CAP_CODE, pref_bot_q, BFW_ADDR_CAP_CODE};
  wire [31:0] io_word = {io_top_hi_q, io_bot_hi_q};
  wire [31:0] mem_new = merge(mem_word, w_data_q, w_strb_q);
  wire [31:0] pref_new = merge(pref_word, w_data_q, w_strb_q);
  wire [31:0] pbot_new = merge(pbot_hi_q, w_data_q, w_strb_q);
  wire [31:0] ptop_new = merge(ptop_hi_q, w_data_q, w_strb_q);
  wire [31:0] io_new = merge(io_word, w_data_q, w_strb_q);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= BFW_WORD_RST;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= BFW_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr_in;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= wdata_in;
        w_strb_q <= wstrb_in;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? BFW_RESP_OKAY : BFW_RESP_SLVERR;
      end else if (bvalid_q && bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register updates
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mem_top_q <= BFW_FIELD12_RST;
      pref_bot_q <= BFW_FIELD12_RST;
      pref_top_q <= BFW_FIELD12_RST;
      pbot_hi_q <= BFW_WORD_RST;
      ptop_hi_q <= BFW_WORD_RST;
      io_bot_hi_q <= BFW_HALF_RST;
      io_top_hi_q <= BFW_HALF_RST;
    end else if (wr_go) begin
      case (wr_word)
        BFW_OFF_MEM: begin
          mem_top_q <= mem_new[31:20];
        end
        BFW_OFF_PREF: begin
          pref_bot_q <= pref_new[15:4];
          pref_top_q <= pref_new[31:20];
        end
        BFW_OFF_PBOT_HI: begin
          pbot_hi_q <= pbot_new;
        end
        BFW_OFF_PTOP_HI: begin
          ptop_hi_q <= ptop_new;
        end
        BFW_OFF_IO_HI: begin
          io_bot_hi_q <= io_new[15:0];
          io_top_hi_q <= io_new[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire ar_take = arvalid_in && arready_q && !rvalid_q;
  wire [7:0] rd_word = {araddr_in[7:2], 2'b00};
  logic [31:0] rd_mux;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    case (rd_word)
      BFW_OFF_MEM: rd_mux = mem_word;
      BFW_OFF_PREF: rd_mux = pref_word;
      BFW_OFF_PBOT_HI: rd_mux = pbot_hi_q;
      BFW_OFF_PTOP_HI: rd_mux = ptop_hi_q;
      BFW_OFF_IO_HI: rd_mux = io_word;
      BFW_OFF_CAP: rd_mux = {24'h00_0000, BFW_CAP_PTR};
      default: begin
        rd_mux = BFW_WORD_RST;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= BFW_WORD_RST;
      rresp_q <= BFW_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? BFW_RESP_OKAY : BFW_RESP_SLVERR;
    end else if (rvalid_q && rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // window assembly and hit decode
  // ----------------------------------------
  wire [63:0] pref_lo = {pbot_hi_q, pref_bot_q, 20'h0_0000};
  wire [63:0] pref_hi = {ptop_hi_q, pref_top_q, BFW_MEM_LOW_ONES};
  wire [63:0] mem_lo = {32'h0000_0000, mem_bottom_in, 20'h0_0000};
  wire [63:0] mem_hi = {32'h0000_0000, mem_top_q, BFW_MEM_LOW_ONES};
  wire [31:0] io_lo = {io_bot_hi_q, io_bottom_low_in, 12'h000};
  wire [31:0] io_hi = {io_top_hi_q, io_top_low_in, BFW_IO_LOW_ONES};
  wire mem_in = (mem_addr_in >= mem_lo) && (mem_addr_in <= mem_hi);
  wire pref_in = (mem_addr_in >= pref_lo) && (mem_addr_in <= pref_hi);
  wire io_in = (io_addr_in >= io_lo) && (io_addr_in <= io_hi);

  // registered so every output comes from a flip-flop; costs one cycle of decode latency
  logic mem_hit_q;
  logic pref_hit_q;
  logic io_hit_q;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mem_hit_q <= 1'b0;
      pref_hit_q <= 1'b0;
      io_hit_q <= 1'b0;
    end else begin
      mem_hit_q <= mem_in;
      pref_hit_q <= pref_in;
      io_hit_q <= io_in;
    end
  end

  // ready flags are registers: held-side flops invert into readiness
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= !(aw_held_q || aw_take) && !(bvalid_q || wr_go);
      wready_q <= !(w_held_q || w_take) && !(bvalid_q || wr_go);
      arready_q <= !(rvalid_q || ar_take);
    end
  end

  assign awready_out = awready_q;
  assign wready_out = wready_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign arready_out = arready_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
  assign mem_hit_out = mem_hit_q;
  assign pref_hit_out = pref_hit_q;
  assign io_hit_out = io_hit_q;
endmodule : bfw_regs

//--- design/bfw_pkg.sv
// package with register map, field layout and reset values for the forwarding window registers
package bfw_pkg;
  localparam logic [7:0] BFW_OFF_MEM = 8'h20;
  localparam logic [7:0] BFW_OFF_PREF = 8'h24;
  localparam logic [7:0] BFW_OFF_PBOT_HI = 8'h28;
  localparam logic [7:0] BFW_OFF_PTOP_HI = 8'h2c;
  localparam logic [7:0] BFW_OFF_IO_HI = 8'h30;
  localparam logic [7:0] BFW_OFF_CAP = 8'h34;
  // low-order io window bits, not held here, come in as ports
  localparam logic [3:0] BFW_ADDR_CAP_CODE = 4'h1;
  localparam logic [7:0] BFW_CAP_PTR = 8'hb0;
  localparam logic [11:0] BFW_FIELD12_RST = 12'h000;
  localparam logic [31:0] BFW_WORD_RST = 32'h0000_0000;
  localparam logic [15:0] BFW_HALF_RST = 16'h0000;
  localparam logic [19:0] BFW_MEM_LOW_ONES = 20'hf_ffff;
  localparam logic [11:0] BFW_IO_LOW_ONES = 12'hfff;
  localparam logic [1:0] BFW_RESP_OKAY = 2'b00;
  localparam logic [1:0] BFW_RESP_SLVERR = 2'b10;
endpackage : bfw_pkg

//--- bench/bfw_regs_sva.sv
// checker for the forwarding window register bank
`timescale 1ns/1ns
module bfw_chk (
  input wire logic mclk_in, reset_in, bvalid_out, bready_in, rvalid_out, rready_in,
  input wire logic arvalid_in, arready_out, mem_hit_out,
  input wire logic [1:0] bresp_out, rresp_out,
  input wire logic [7:0] araddr_in,
  input wire logic [31:0] rdata_out,
  input wire logic [11:0] mem_bottom_in,
  input wire logic [63:0] mem_addr_in
);
  import bfw_pkg::*;
  // word address of the read in flight, so read data can be tied to its register
  logic [7:0] ra_q;
  always_ff @(posedge mclk_in) begin
    if (arvalid_in && arready_out) ra_q <= {araddr_in[7:2], 2'b00};
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_ar_take;
    arvalid_in && arready_out;
  endsequence
  sequence s_rd_at(logic [7:0] off);
    rvalid_out && ra_q == off;
  endsequence
  a_rd_answer: assert property (s_ar_take |=> rvalid_out)
    else $error("read answer missing");
  a_b_hold: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data dropped early");
  a_cap_value: assert property (s_rd_at(BFW_OFF_CAP) |-> rdata_out[7:0] == BFW_CAP_PTR)
    else $error("capability pointer wrong");
  a_mem_ro: assert property (s_rd_at(BFW_OFF_MEM) |-> rdata_out[19:16] == 4'h0)
    else $error("memory top low nibble not zero");
  a_pref_code: assert property (s_rd_at(BFW_OFF_PREF) |-> {rdata_out[19:16], rdata_out[3:0]} == 8'h11)
    else $error("addressing code wrong");
  a_unmapped_err: assert property (rvalid_out && (ra_q < BFW_OFF_MEM || ra_q > BFW_OFF_CAP) |-> rresp_out == BFW_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_mem_below: assert property (mem_addr_in < {32'h0000_0000, mem_bottom_in, 20'h0_0000} |=> !mem_hit_out)
    else $error("memory hit below window");
endmodule : bfw_chk
bind bfw_regs bfw_chk chk_u (.mclk_in(mclk_in), .reset_in(reset_in), .bvalid_out(bvalid_out),
  .bready_in(bready_in), .rvalid_out(rvalid_out), .rready_in(rready_in), .arvalid_in(arvalid_in),
  .arready_out(arready_out), .mem_hit_out(mem_hit_out), .bresp_out(bresp_out), .rresp_out(rresp_out),
  .araddr_in(araddr_in), .rdata_out(rdata_out), .mem_bottom_in(mem_bottom_in), .mem_addr_in(mem_addr_in));

//--- bench/testbench.sv
// self-checking testbench for the forwarding window register bank
`timescale 1ns/1ns
`define CMP(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module testbench;
  import bfw_pkg::*;
  logic mclk_in = 0, reset_in = 1, awvalid_in = 0, wvalid_in = 0, bready_in = 0, arvalid_in = 0, rready_in = 0;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, mem_hit_out, pref_hit_out, io_hit_out;
  logic [7:0] awaddr_in = 0, araddr_in = 0;
  logic [31:0] wdata_in = 0, io_addr_in = 0, rdata_out, d;
  logic [3:0] wstrb_in = 0, io_bottom_low_in = 4'h3, io_top_low_in = 4'h5;
  logic [11:0] mem_bottom_in = 12'h100;
  logic [63:0] mem_addr_in = 0;
  logic [1:0] bresp_out, rresp_out, r;
  int n_fail = 0, compares = 0, cyc = 0;
  logic [7:0] offs [6] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
  // prefetch fields have no stated reset, so only the fixed code nibbles are masked in
  logic [31:0] msk [6] = '{32'hffff_ffff, 32'h000f_000f, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_00ff};
  logic [31:0] rstv [6] = '{32'h0000_0000, 32'h0001_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_00b0};
  logic [31:0] onev [6] = '{32'hfff0_0000, 32'hfff1_fff1, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_00b0};
  logic [63:0] ma [7] = '{64'h0000_0001_1000_0000, 64'h0000_0001_0fff_ffff, 64'h0000_0001_1fff_ffff,
    64'h0000_0001_2000_0000, 64'h0000_0000_200f_ffff, 64'h0000_0000_2010_0000, 64'h0000_0000_1000_0000};
  logic [31:0] ia [7] = '{32'h0001_3000, 32'h0001_2fff, 32'h0002_5fff, 32'h0002_6000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};
  logic [2:0] eh [7] = '{3'h3, 3'h0, 3'h3, 3'h0, 3'h4, 3'h0, 3'h4};
  always #50 mclk_in = ~mclk_in;
  bfw_regs dut_u (.mclk_in(mclk_in), .reset_in(reset_in), .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
    .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in), .wvalid_in(wvalid_in),
    .wready_out(wready_out), .bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
    .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out), .rdata_out(rdata_out),
    .rresp_out(rresp_out), .rvalid_out(rvalid_out), .rready_in(rready_in), .mem_bottom_in(mem_bottom_in),
    .io_bottom_low_in(io_bottom_low_in), .io_top_low_in(io_top_low_in), .mem_addr_in(mem_addr_in),
    .io_addr_in(io_addr_in), .mem_hit_out(mem_hit_out), .pref_hit_out(pref_hit_out), .io_hit_out(io_hit_out));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // each valid is held until its ready is seen; bready is raised with them, so the response is taken in its first valid cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    bit ad = 0;
    bit wd = 0;
    awaddr_in <= a;
    wdata_in <= v;
    wstrb_in <= s;
    awvalid_in <= 1;
    wvalid_in <= 1;
    bready_in <= 1;
    while (!(ad && wd)) begin
      @(posedge mclk_in);
      ad = ad | awready_out;
      wd = wd | wready_out;
      awvalid_in <= !ad;
      wvalid_in <= !wd;
    end
    do @(posedge mclk_in); while (!bvalid_out);
    r = bresp_out;
    bready_in <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr_in <= a;
    arvalid_in <= 1;
    rready_in <= 1;
    do @(posedge mclk_in); while (!arready_out);
    arvalid_in <= 0;
    do @(posedge mclk_in); while (!rvalid_out);
    d = rdata_out;
    r = rresp_out;
    rready_in <= 0;
  endtask : rd
  initial begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 0;
    for (int i = 0; i < 6; i++) begin
      rd(offs[i]);
      `CMP("reset value", rstv[i], d & msk[i])
      wr(offs[i], 32'hffff_ffff, 4'hf);
      `CMP("write resp", BFW_RESP_OKAY, r)
      rd(offs[i]);
      `CMP("ones value", onev[i], d)
    end
    wr(8'h28, 32'h1234_5678, 4'h5);
    rd(8'h28);
    `CMP("strobed word", 32'hff34_ff78, d)
    wr(8'h38, 32'h0000_0001, 4'hf);
    `CMP("unmapped wr", BFW_RESP_SLVERR, r)
    rd(8'h38);
    `CMP("unmapped rd", {BFW_RESP_SLVERR, 32'h0000_0000}, {r, d})
    wr(8'h24, 32'h1ff0_1000, 4'hf);
    wr(8'h28, 32'h0000_0001, 4'hf);
    wr(8'h2c, 32'h0000_0001, 4'hf);
    wr(8'h20, 32'h2000_0000, 4'hf);
    wr(8'h30, 32'h0002_0001, 4'hf);
    for (int i = 0; i < 7; i++) begin
      mem_addr_in <= ma[i];
      io_addr_in <= ia[i];
      repeat (2) @(posedge mclk_in);
      `CMP("window hits", eh[i], {mem_hit_out, pref_hit_out, io_hit_out})
    end
    tally_and_finish();
  end
endmodule : testbench
